// File: sstm_cfg.svh
// Constants for the safe signal telegram mapper
`ifndef SSTM_CFG_SVH
`define SSTM_CFG_SVH
`define SSTM_OUT_BYTES      11
`define SSTM_IN_BYTES       7
`define SSTM_OB_BANK        0
`define SSTM_OB_RSV1        1
`define SSTM_OB_SWITCH      2
`define SSTM_OB_RSV3        3
`define SSTM_OB_RST_A       4
`define SSTM_OB_RST_B       5
`define SSTM_OB_STATUS      6
`define SSTM_OB_CRC         7
`define SSTM_IB_FN_A        0
`define SSTM_IB_FN_B        1
`define SSTM_IB_STATUS      2
`define SSTM_IB_CRC         3
`define SSTM_SEL_W          5
`define SSTM_BIT_WF         0
`define SSTM_BIT_PF         1
`define SSTM_MODE_W         3
`define SSTM_PROTO_VER      8'h26
`define SSTM_MODULE_ID      32'h0000A5A1
`define SSTM_SUBMODULE_ID   32'h0000A5B2
`endif

// File: sstm_pkg.sv
// Types for the safe signal telegram mapper
package sstm_pkg;
  typedef logic [7:0] sstm_byte_t;
  typedef enum logic [5:0] {
    SSTM_ONE_5_10    = 6'h01,
    SSTM_ONE_100     = 6'h02,
    SSTM_ONE_MULTI   = 6'h04,
    SSTM_TWO         = 6'h08,
    SSTM_TWO_FOUR    = 6'h10,
    SSTM_TWO_MULTI   = 6'h20
  } sstm_mode_e;
  typedef struct packed {
    logic [4:0] bank_sel;
    logic [4:0] switch_sel;
    logic       a_wf_restart;
    logic       a_pf_restart;
    logic       b_wf_restart;
    logic       b_pf_restart;
  } sstm_cmd_s;
endpackage

// File: sstm_if.sv
`timescale 1ns/1ps
// Carrier between telegram mapper and output decoder
interface sstm_if;
  import sstm_pkg::*;
  logic [8*6-1:0] payload;
  sstm_mode_e     mode;
  sstm_cmd_s      cmd;
  logic           mode_ok;
  modport decoder (input payload, input mode, output cmd, output mode_ok);
  modport mapper  (output payload, output mode, input cmd, input mode_ok);
endinterface

// File: sstm_out_decode.sv
`timescale 1ns/1ps
// Output payload decoder, mode dependent
module sstm_out_decode
  import sstm_pkg::*;
(
  sstm_if.decoder dec
);
`include "sstm_cfg.svh"

  // Byte picker used for every field
  function automatic sstm_byte_t pick(input logic [8*6-1:0] p, input int idx);
    pick = p[idx*8 +: 8];
  endfunction

  wire sstm_byte_t b0 = pick(dec.payload, `SSTM_OB_BANK);
  wire sstm_byte_t b2 = pick(dec.payload, `SSTM_OB_SWITCH);
  wire sstm_byte_t b4 = pick(dec.payload, `SSTM_OB_RST_A);
  wire sstm_byte_t b5 = pick(dec.payload, `SSTM_OB_RST_B);
  wire             two_multi = (dec.mode == SSTM_TWO_MULTI);

  // Only the shared multi-config layout is mapped; other modes decode idle
  assign dec.mode_ok             = two_multi;
  assign dec.cmd.bank_sel        = two_multi ? b0[`SSTM_SEL_W-1:0] : '0;
  assign dec.cmd.switch_sel      = two_multi ? b2[`SSTM_SEL_W-1:0] : '0;
  assign dec.cmd.a_wf_restart    = two_multi & b4[`SSTM_BIT_WF];
  assign dec.cmd.a_pf_restart    = two_multi & b4[`SSTM_BIT_PF];
  assign dec.cmd.b_wf_restart    = two_multi & b5[`SSTM_BIT_WF];
  assign dec.cmd.b_pf_restart    = two_multi & b5[`SSTM_BIT_PF];
endmodule

// File: sstm_telegram_map.sv
// Safe signal telegram mapper, two-function multi-configuration mode
// Summary of operation
// - Input byte 0: bit0 warning free, bit1 protective free, function A.
// - Input byte 1: bit0 warning free, bit1 protective free, function B.
// - Output byte 0 bits 0-4 carry shared configuration bank selection.
// - Output byte 2 bits 0-4 carry shared field switchover selection.
// - Output byte 4: warning and protective restart requests, function A.
// - Output byte 5: warning and protective restart requests, function B.
// - Output payload decoded only in two-function multi-configuration mode; other modes give idle commands.
// - Module reports protocol version and fixed 32-bit identifiers.
// - Output: data bytes 0-5, status byte 6, CRC bytes 7-10 MSB first.
`timescale 1ns/1ps
`include "sstm_cfg.svh"
module sstm_telegram_map
  import sstm_pkg::*;
#(
  parameter logic [31:0] MODULE_ID    = `SSTM_MODULE_ID,     // Arbitrary value
  parameter logic [31:0] SUBMODULE_ID = `SSTM_SUBMODULE_ID   // Arbitrary value
)(
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       out_valid_i,
  input  wire logic [8*`SSTM_OUT_BYTES-1:0] out_telegram_i,
  input  wire logic [5:0]                 mode_i,
  input  wire logic                       fn_a_warning_field_free_i,
  input  wire logic                       fn_a_protective_field_free_i,
  input  wire logic                       fn_b_warning_field_free_i,
  input  wire logic                       fn_b_protective_field_free_i,
  input  wire logic [7:0]                 in_status_i,
  input  wire logic [31:0]                in_crc_i,
  output logic [8*`SSTM_IN_BYTES-1:0]     in_telegram_o,
  output logic [4:0]                      bank_sel_o,
  output logic [4:0]                      switch_sel_o,
  output logic                            fn_a_wf_restart_o,
  output logic                            fn_a_pf_restart_o,
  output logic                            fn_b_wf_restart_o,
  output logic                            fn_b_pf_restart_o,
  output logic                            mode_ok_o,
  output logic [7:0]                      out_status_o,
  output logic [31:0]                     out_crc_o,
  output logic [7:0]                      proto_version_o,
  output logic [31:0]                     module_id_o,
  output logic [31:0]                     submodule_id_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers for field flags (from the scanner core pins)
  logic [3:0] flag_meta;
  logic [3:0] flag_sync;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flag_meta <= 4'h0;
      flag_sync <= 4'h0;
    end else begin
      flag_meta <= {fn_b_protective_field_free_i, fn_b_warning_field_free_i,
                    fn_a_protective_field_free_i, fn_a_warning_field_free_i};
      flag_sync <= flag_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Input telegram assembly; reserved bits zero
  wire sstm_byte_t in_b0 = {6'h00, flag_sync[1], flag_sync[0]};
  wire sstm_byte_t in_b1 = {6'h00, flag_sync[3], flag_sync[2]};
  wire [8*`SSTM_IN_BYTES-1:0] next_in_telegram =
    {in_crc_i[7:0], in_crc_i[15:8], in_crc_i[23:16], in_crc_i[31:24],
     in_status_i, in_b1, in_b0};

  //////////////////////////////////////////////////////////////////////////////
  // Output telegram split: payload, status, CRC (byte 7 is most significant)
  sstm_if bus ();
  wire sstm_byte_t ob_status = out_telegram_i[`SSTM_OB_STATUS*8 +: 8];
  wire [31:0] ob_crc = {out_telegram_i[(`SSTM_OB_CRC+0)*8 +: 8],
                        out_telegram_i[(`SSTM_OB_CRC+1)*8 +: 8],
                        out_telegram_i[(`SSTM_OB_CRC+2)*8 +: 8],
                        out_telegram_i[(`SSTM_OB_CRC+3)*8 +: 8]};
  assign bus.payload = out_telegram_i[8*6-1:0];
  assign bus.mode    = sstm_mode_e'(mode_i);

  sstm_out_decode u_dec (
    .dec (bus.decoder)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Registered outputs; commands update only on a valid telegram
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      in_telegram_o     <= '0;
      bank_sel_o        <= 5'h00;
      switch_sel_o      <= 5'h00;
      fn_a_wf_restart_o <= 1'b0;
      fn_a_pf_restart_o <= 1'b0;
      fn_b_wf_restart_o <= 1'b0;
      fn_b_pf_restart_o <= 1'b0;
      mode_ok_o         <= 1'b0;
      out_status_o      <= 8'h00;
      out_crc_o         <= 32'h0;
    end else begin
      in_telegram_o <= next_in_telegram;
      if (out_valid_i) begin
        bank_sel_o        <= bus.cmd.bank_sel;
        switch_sel_o      <= bus.cmd.switch_sel;
        fn_a_wf_restart_o <= bus.cmd.a_wf_restart;
        fn_a_pf_restart_o <= bus.cmd.a_pf_restart;
        fn_b_wf_restart_o <= bus.cmd.b_wf_restart;
        fn_b_pf_restart_o <= bus.cmd.b_pf_restart;
        mode_ok_o         <= bus.mode_ok;
        out_status_o      <= ob_status;
        out_crc_o         <= ob_crc;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fixed identity and protocol version
  always_ff @(posedge ref_clk_i) begin
    proto_version_o <= `SSTM_PROTO_VER;
    module_id_o     <= MODULE_ID;
    submodule_id_o  <= SUBMODULE_ID;
  end
endmodule

// File: sstm_ctrl_model.sv
// Controller model that assembles the output telegram
`timescale 1ns/1ps
module sstm_ctrl_model (
  input  wire logic [13:0] cmd_i,
  input  wire logic [39:0] tail_i,
  input  wire logic [7:0]  junk_i,
  output logic      [87:0] tel_o
);
  // Fields and restarts move only through their bits; junk_i fills reserved bits
  wire logic [31:0] crc = {<<8{tail_i[31:0]}};
  assign tel_o = {crc, tail_i[39:32], junk_i[7:2], cmd_i[3:2], junk_i[7:2], cmd_i[1:0],
                  junk_i, junk_i[7:5], cmd_i[8:4], junk_i, junk_i[7:5], cmd_i[13:9]};
endmodule

// File: sstm_monitor.sv
// Assertion checker on the telegram mapper ports
`timescale 1ns/1ps
module sstm_monitor
  import sstm_pkg::*;
#(parameter logic [31:0] MODULE_ID = 32'h0)(
  input wire logic        ref_clk_i, rst_i, out_valid_i, mode_ok_o,
  input wire logic [87:0] out_telegram_i,
  input wire logic [5:0]  mode_i,
  input wire logic        fn_a_warning_field_free_i, fn_a_protective_field_free_i,
  input wire logic        fn_b_warning_field_free_i, fn_b_protective_field_free_i,
  input wire logic        fn_a_wf_restart_o, fn_a_pf_restart_o,
  input wire logic        fn_b_wf_restart_o, fn_b_pf_restart_o,
  input wire logic [7:0]  in_status_i, proto_version_o,
  input wire logic [31:0] in_crc_i, out_crc_o, module_id_o,
  input wire logic [55:0] in_telegram_o,
  input wire logic [4:0]  bank_sel_o, switch_sel_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Packed pins, restarts and byte-reversed CRCs
  wire logic [3:0]  pin = {fn_b_protective_field_free_i, fn_b_warning_field_free_i,
                           fn_a_protective_field_free_i, fn_a_warning_field_free_i};
  wire logic [3:0]  rq = {fn_b_pf_restart_o, fn_b_wf_restart_o, fn_a_pf_restart_o, fn_a_wf_restart_o};
  wire logic [31:0] ocrc = {<<8{out_crc_o}};
  wire logic [31:0] icrc = {<<8{in_telegram_o[55:24]}};
  sequence s_take; out_valid_i && mode_i == SSTM_TWO_MULTI; endsequence
  sequence s_steady; $stable(pin) [*3]; endsequence
  ////////////////////////////////////////////////////////////////
  property p_bank; s_take |=> bank_sel_o == $past(out_telegram_i[4:0]); endproperty
  a_bank: assert property (p_bank) else $error("bank select");
  property p_sw; s_take |=> switch_sel_o == $past(out_telegram_i[20:16]); endproperty
  a_sw: assert property (p_sw) else $error("switchover select");
  property p_ra; s_take |=> mode_ok_o && rq[1:0] == $past(out_telegram_i[33:32]); endproperty
  a_ra: assert property (p_ra) else $error("restart A");
  property p_rb; s_take |=> rq[3:2] == $past(out_telegram_i[41:40]); endproperty
  a_rb: assert property (p_rb) else $error("restart B");
  property p_off;
    out_valid_i && mode_i != SSTM_TWO_MULTI |=> !mode_ok_o && {rq, bank_sel_o} == 9'h000;
  endproperty
  a_off: assert property (p_off) else $error("other mode decoded");
  property p_crc; out_valid_i |=> ocrc == $past(out_telegram_i[87:56]); endproperty
  a_crc: assert property (p_crc) else $error("output crc");
  property p_in; 1'b1 |=> in_telegram_o[23:16] == $past(in_status_i) && icrc == $past(in_crc_i);
  endproperty
  a_in: assert property (p_in) else $error("input status or crc");
  property p_flag;
    s_steady |=> in_telegram_o[15:0] == {6'h00, $past(pin[3:2]), 6'h00, $past(pin[1:0])};
  endproperty
  a_flag: assert property (p_flag) else $error("field flags");
  property p_id; proto_version_o == 8'h26 && module_id_o == MODULE_ID; endproperty
  a_id: assert property (p_id) else $error("identity");
endmodule
bind sstm_telegram_map sstm_monitor #(.MODULE_ID(MODULE_ID)) u_mon (.*);

// File: sstm_telegram_map_tb.sv
// Self-checking bench for the telegram mapper
`timescale 1ns/1ps
`include "sstm_cfg.svh"
module sstm_telegram_map_tb;
  import sstm_pkg::*;
  logic        ref_clk_i = 1'b0, rst_i = 1'b1, out_valid_i = 1'b0;
  logic [5:0]  mode_i = 6'h20;
  logic [3:0]  pin = 4'h0;
  logic [7:0]  junk = 8'h00;
  logic [13:0] cmd = 14'h0, e_cmd = 14'h0;
  logic [39:0] otl = 40'h0, inc = 40'h0, e_otl = 40'h0;
  logic [31:0] seed = 32'hE60C, r;
  wire logic [87:0] tel;
  wire logic [55:0] itl;
  wire logic [4:0]  bank, sw;
  wire logic [3:0]  rq;
  wire logic [7:0]  ost, ver;
  wire logic [31:0] ocrc, mid, sid;
  wire logic        ok;
  int               n_mismatch = 0, compares = 0, cyc = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  sstm_ctrl_model ctrl (.cmd_i(cmd), .tail_i(otl), .junk_i(junk), .tel_o(tel));
  sstm_telegram_map uut (.ref_clk_i, .rst_i, .out_valid_i, .out_telegram_i(tel), .mode_i,
    .fn_a_warning_field_free_i(pin[0]), .fn_a_protective_field_free_i(pin[1]),
    .fn_b_warning_field_free_i(pin[2]), .fn_b_protective_field_free_i(pin[3]),
    .in_status_i(inc[39:32]), .in_crc_i(inc[31:0]), .in_telegram_o(itl), .bank_sel_o(bank),
    .switch_sel_o(sw), .fn_a_wf_restart_o(rq[0]), .fn_a_pf_restart_o(rq[1]),
    .fn_b_wf_restart_o(rq[2]), .fn_b_pf_restart_o(rq[3]), .mode_ok_o(ok), .out_status_o(ost),
    .out_crc_o(ocrc), .proto_version_o(ver), .module_id_o(mid), .submodule_id_o(sid));
  // Random source and expected input telegram tail
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed;
  endfunction
  function automatic logic [39:0] exp_in(input logic [39:0] t);
    return {t[7:0], t[15:8], t[23:16], t[31:24], t[39:32]};
  endfunction
  task automatic chk(input string nm, input logic [87:0] seen, input logic [87:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Cycle ceiling against hangs
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc > 1000) begin
      n_mismatch++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////
  // Reset values, then corner and random telegrams
  initial begin
    repeat (8) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk("reset", {ok, rq, sw, bank, ver, mid, sid},
        {15'h0, 8'h26, `SSTM_MODULE_ID, `SSTM_SUBMODULE_ID});
    rst_i = 1'b0;
    $display("reset test done");
    for (int i = 0; i < 400; i++) begin
      r = (i < 2) ? '1 : (i == 2) ? 32'h1 : rnd();
      out_valid_i = r[0];
      mode_i = (r[3:1] > 3'd5) ? 6'h20 : 6'h01 << r[3:1];
      cmd = r[17:4];
      junk = r[25:18];
      otl = {r[31:24], rnd()};
      inc = {r[15:8], rnd()};
      if (i % 4 == 0) pin = r[29:26];
      @(posedge ref_clk_i);
      if (out_valid_i) begin
        e_cmd = (mode_i == SSTM_TWO_MULTI) ? cmd : 14'h0;
        e_otl = otl;
      end
      #1;
      chk("cmd", {bank, sw, rq}, e_cmd);
      chk("out tail", {ost, ocrc}, e_otl);
      chk("in tail", itl[55:16], exp_in(inc));
      if (out_valid_i) chk("mode ok", ok, mode_i == SSTM_TWO_MULTI);
      if (i % 4 == 3) chk("flags", itl[15:0], {6'h0, pin[3:2], 6'h0, pin[1:0]});
      @(negedge ref_clk_i);
    end
    $display("random test done");
    final_report();
  end
endmodule
